// >>> rss_pkg.sv
package rss_pkg;

	////////////////////////////////////////////////////////////////////////
	// Widths and depths
	////////////////////////////////////////////////////////////////////////
	localparam int PC_W   = 21;                  // Program counter width
	localparam int PTR_W  = 5;                   // Stack pointer width
	localparam int DEPTH  = 32;                  // Entries, slot 0 never written by a push
	localparam int DATA_W = 8;                   // Register bus data width
	localparam int ADDR_W = 4;                   // Register bus address width
	localparam int N_TOS_BYTES = 3;              // Low, high, upper bytes

	////////////////////////////////////////////////////////////////////////
	// Register offsets
	////////////////////////////////////////////////////////////////////////
	localparam logic [ADDR_W-1:0] OFF_TOP_ENTRY_LOW_BYTE   = 4'h0;
	localparam logic [ADDR_W-1:0] OFF_TOP_ENTRY_HIGH_BYTE  = 4'h1;
	localparam logic [ADDR_W-1:0] OFF_TOP_ENTRY_UPPER_BYTE = 4'h2;
	localparam logic [ADDR_W-1:0] OFF_RETURN_STACK_POINTER = 4'h3;
	localparam logic [ADDR_W-1:0] OFF_IRQ_STATUS           = 4'h4;
	localparam logic [ADDR_W-1:0] OFF_IRQ_MASK             = 4'h5;

	////////////////////////////////////////////////////////////////////////
	// Field positions
	////////////////////////////////////////////////////////////////////////
	localparam int FULL_BIT  = 7;                // Stack full flag
	localparam int UNF_BIT   = 6;                // Stack underflow flag
	localparam int EV_FULL   = 0;                // Interrupt status bit, full
	localparam int EV_UNF    = 1;                // Interrupt status bit, underflow
	localparam int N_EVENTS  = 2;                // Interrupt sources

	////////////////////////////////////////////////////////////////////////
	// Values after reset and limits
	////////////////////////////////////////////////////////////////////////
	localparam logic [PTR_W-1:0]    PTR_RST   = 5'h00;
	localparam logic [PTR_W-1:0]    PTR_MAX   = 5'h1f;
	localparam logic [PTR_W-1:0]    PTR_EMPTY = 5'h00;
	localparam logic [N_EVENTS-1:0] IRQ_RST   = 2'h0;
	localparam logic [DATA_W-1:0]   SHADOW_RST = 8'h00;

	////////////////////////////////////////////////////////////////////////
	// Types
	////////////////////////////////////////////////////////////////////////
	// Sequencer requests, all one-cycle pulses
	typedef struct packed {
		logic            push;
		logic            pop;
		logic            vector_int;
		logic            fast_call;
		logic            fast_return;
		logic [PC_W-1:0] pc;
	} rss_seq_req_t;

	// Status, working and bank-select register set
	typedef struct packed {
		logic [DATA_W-1:0] status;
		logic [DATA_W-1:0] working_register;
		logic [DATA_W-1:0] bank_select_register;
	} rss_core_regs_t;

	// Register bus request
	typedef struct packed {
		logic              wr;
		logic              rd;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} rss_bus_req_t;

	// Stack error reset sequencer
	typedef enum logic {
		ERR_IDLE,
		ERR_RESET
	} rss_err_state_t;

endpackage

// >>> rss_stack_mem.sv
`timescale 1ns/1ps
module rss_stack_mem
	import rss_pkg::*;
(
	input  wire logic                  core_clk,
	input  wire logic                  ce,
	input  wire logic                  we,
	input  wire logic [PTR_W-1:0]      waddr,
	input  wire logic [PC_W-1:0]       wdata,
	input  wire logic [PTR_W-1:0]      raddr,
	output logic      [PC_W-1:0]       rdata
);
	import rss_pkg::*;

	logic [PC_W-1:0] mem [DEPTH];            // Stack entries, no reset needed

	////////////////////////////////////////////////////////////////////////
	// Write port
	always_ff @(posedge core_clk) begin
		if (ce && we) begin
			mem[waddr] <= wdata;
		end
	end

	// Registered read, write-first so a fresh push is seen at once
	always_ff @(posedge core_clk) begin
		if (ce) begin
			if (we && (waddr == raddr)) begin
				rdata <= wdata;
			end else begin
				rdata <= mem[raddr];
			end
		end
	end

endmodule

// >>> rss_shadow.sv
`timescale 1ns/1ps
module rss_shadow
	import rss_pkg::*;
(
	input  wire logic                  core_clk,
	input  wire logic                  rst,
	input  wire logic                  ce,
	input  wire logic                  save,
	input  wire logic                  restore,
	input  rss_pkg::rss_core_regs_t    live,
	output logic                       restore_valid,
	output rss_pkg::rss_core_regs_t    restored
);
	import rss_pkg::*;

	rss_core_regs_t shadow_reg;              // One level, hidden from software

	////////////////////////////////////////////////////////////////////////
	// Capture; a later save simply overwrites, there is one level only
	always_ff @(posedge core_clk) begin
		if (rst) begin
			shadow_reg <= '{SHADOW_RST, SHADOW_RST, SHADOW_RST};
		end else if (ce && save) begin
			shadow_reg <= live;
		end
	end

	// Restore strobe and copied-back values
	always_ff @(posedge core_clk) begin
		if (rst) begin
			restore_valid <= 1'b0;
			restored      <= '{SHADOW_RST, SHADOW_RST, SHADOW_RST};
		end else if (ce) begin
			restore_valid <= restore;
			if (restore) begin
				restored <= shadow_reg;
			end
		end
	end

endmodule

// >>> rss_top.sv
`timescale 1ns/1ps
module rss_top
	import rss_pkg::*;
(
	input  wire logic                       core_clk,
	input  wire logic                       rst,
	input  wire logic                       ce,
	input  rss_pkg::rss_bus_req_t           bus_req,
	output logic      [rss_pkg::DATA_W-1:0] bus_rdata,
	input  rss_pkg::rss_seq_req_t           seq_req,
	input  rss_pkg::rss_core_regs_t         core_regs,
	input  wire logic                       stack_error_reset_enable,
	output logic      [rss_pkg::PC_W-1:0]   top_of_stack,
	output logic      [rss_pkg::PTR_W-1:0]  stack_ptr,
	output logic                            restore_valid,
	output rss_pkg::rss_core_regs_t         restored_regs,
	output logic                            stack_reset_req,
	output logic                            irq
);
	import rss_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// Declarations
	////////////////////////////////////////////////////////////////////////
	logic [PTR_W-1:0]    ptr_reg;            // Current stack location
	logic [PTR_W-1:0]    ptr_next;           // Location after this cycle
	logic                full_reg;           // Stack full flag
	logic                unf_reg;            // Stack underflow flag
	logic                mem_we;             // Stack entry write
	logic [PTR_W-1:0]    mem_waddr;          // Entry being written
	logic [PC_W-1:0]     mem_wdata;          // Value being written
	logic [PC_W-1:0]     tos_q;              // Registered top entry
	logic [PC_W-1:0]     tos_merged;         // Top entry with one byte replaced
	logic                do_push;            // Push accepted this cycle
	logic                do_pop;             // Pop accepted this cycle
	logic                ev_full;            // Stack became full or overflowed
	logic                ev_unf;             // Pop with empty stack
	logic                wr_ptr;             // Software write to pointer register
	logic                wr_tos;             // Software write to a top byte
	logic [N_EVENTS-1:0] irq_status_reg;     // Sticky event bits
	logic [N_EVENTS-1:0] irq_mask_reg;       // Event enables
	logic [N_EVENTS-1:0] irq_events;         // Events of this cycle
	logic [DATA_W-1:0]   rd_mux;             // Read data before the register
	rss_err_state_t      err_state_reg;      // Reset sequencer state
	rss_err_state_t      err_state_next;     // Its next value
	logic                err_arm_reg;        // Enabled event seen last cycle

	////////////////////////////////////////////////////////////////////////
	// Helpers
	////////////////////////////////////////////////////////////////////////
	// Address decode, used by both the write and the read paths
	function automatic logic reg_hit(
		input logic [ADDR_W-1:0] addr,
		input logic [ADDR_W-1:0] off
	);
		reg_hit = (addr == off);
	endfunction

	// Offset of a top entry byte by its lane number
	function automatic logic [ADDR_W-1:0] tos_off(input int lane);
		logic [ADDR_W-1:0] off;
		off = OFF_TOP_ENTRY_LOW_BYTE;
		unique case (lane)
			1: off = OFF_TOP_ENTRY_HIGH_BYTE;
			2: off = OFF_TOP_ENTRY_UPPER_BYTE;
			default: off = OFF_TOP_ENTRY_LOW_BYTE;
		endcase
		tos_off = off;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Sequencer decode
	////////////////////////////////////////////////////////////////////////
	// Push and pop together are not a legal request; push is taken
	always_comb begin
		do_push = seq_req.push;
		do_pop  = seq_req.pop && !seq_req.push;
	end

	// Full when a push lands on the last slot or finds it taken
	always_comb begin
		ev_full = do_push && (ptr_reg >= (PTR_MAX - 5'h01));
		ev_unf  = do_pop && (ptr_reg == PTR_EMPTY);
	end

	////////////////////////////////////////////////////////////////////////
	// Software write decode
	////////////////////////////////////////////////////////////////////////
	always_comb begin
		wr_ptr = bus_req.wr && reg_hit(bus_req.addr, OFF_RETURN_STACK_POINTER);
		wr_tos = 1'b0;
		for (int i = 0; i < N_TOS_BYTES; i++) begin
			if (bus_req.wr && reg_hit(bus_req.addr, tos_off(i))) begin
				wr_tos = 1'b1;
			end
		end
	end

	// Byte lane replacement of the top entry; the upper lane is short
	generate
		for (genvar g = 0; g < N_TOS_BYTES; g++) begin : g_lane
			localparam int LO = g * DATA_W;
			localparam int HI = ((g + 1) * DATA_W > PC_W) ? PC_W - 1
			                                              : (g + 1) * DATA_W - 1;
			always_comb begin
				if (reg_hit(bus_req.addr, tos_off(g))) begin
					tos_merged[HI:LO] = bus_req.wdata[HI-LO:0];
				end else begin
					tos_merged[HI:LO] = tos_q[HI:LO];
				end
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// Stack pointer
	////////////////////////////////////////////////////////////////////////
	// Core operations outrank a software pointer write in the same cycle
	always_comb begin
		ptr_next = ptr_reg;
		if (do_push) begin
			if (ptr_reg != PTR_MAX) begin
				ptr_next = ptr_reg + 5'h01;
			end
		end else if (do_pop) begin
			if (ptr_reg != PTR_EMPTY) begin
				ptr_next = ptr_reg - 5'h01;
			end
		end else if (wr_ptr) begin
			ptr_next = bus_req.wdata[PTR_W-1:0];
		end
	end

	// Saturation keeps the pointer inside the stack either way
	always_ff @(posedge core_clk) begin
		if (rst) begin
			ptr_reg <= PTR_RST;
		end else if (ce) begin
			ptr_reg <= ptr_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Stack entry writes
	////////////////////////////////////////////////////////////////////////
	// An overflowing push is dropped so the last entry is kept intact
	always_comb begin
		mem_we    = 1'b0;
		mem_waddr = ptr_reg;
		mem_wdata = tos_merged;
		if (do_push) begin
			mem_we    = (ptr_reg != PTR_MAX);
			mem_waddr = ptr_reg + 5'h01;
			mem_wdata = seq_req.pc;
		end else if (wr_tos && !do_pop) begin
			mem_we    = 1'b1;
		end
	end

	// Entry store; read address follows the pointer's next value
	rss_stack_mem u_mem (
		.core_clk (core_clk),
		.ce       (ce),
		.we       (mem_we),
		.waddr    (mem_waddr),
		.wdata    (mem_wdata),
		.raddr    (ptr_next),
		.rdata    (tos_q)
	);

	////////////////////////////////////////////////////////////////////////
	// Full and underflow flags
	////////////////////////////////////////////////////////////////////////
	// Software writes zero to clear; a one leaves the flag alone
	always_ff @(posedge core_clk) begin
		if (rst) begin
			full_reg <= 1'b0;
		end else if (ce) begin
			if (ev_full) begin
				full_reg <= 1'b1;
			end else if (wr_ptr && !bus_req.wdata[FULL_BIT]) begin
				full_reg <= 1'b0;
			end
		end
	end

	// Same scheme; an event beside a clearing write wins
	always_ff @(posedge core_clk) begin
		if (rst) begin
			unf_reg <= 1'b0;
		end else if (ce) begin
			if (ev_unf) begin
				unf_reg <= 1'b1;
			end else if (wr_ptr && !bus_req.wdata[UNF_BIT]) begin
				unf_reg <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Stack error reset
	////////////////////////////////////////////////////////////////////////
	// Arm on the event edge, together with the flag; the pulse comes a
	// cycle later so software-visible state leads the device reset
	always_ff @(posedge core_clk) begin
		if (rst) begin
			err_arm_reg <= 1'b0;
		end else if (ce) begin
			err_arm_reg <= (ev_full || ev_unf) && stack_error_reset_enable;
		end
	end

	// Flag is set on the event edge, the reset pulse follows one cycle
	// later so the flag is already visible when the reset goes out
	always_comb begin
		err_state_next = ERR_IDLE;
		unique case (err_state_reg)
			ERR_IDLE: begin
				if (err_arm_reg) begin
					err_state_next = ERR_RESET;
				end
			end
			ERR_RESET: begin
				err_state_next = ERR_IDLE;
			end
		endcase
	end

	// Sequencer state
	always_ff @(posedge core_clk) begin
		if (rst) begin
			err_state_reg <= ERR_IDLE;
		end else if (ce) begin
			err_state_reg <= err_state_next;
		end
	end

	// With the enable low the flags alone record the event
	always_comb begin
		stack_reset_req = (err_state_reg == ERR_RESET);
	end

	////////////////////////////////////////////////////////////////////////
	// Shadow register set
	////////////////////////////////////////////////////////////////////////
	// Every vector saves, so a nested high priority entry overwrites
	// what the low priority entry stored; software must save its own
	rss_shadow u_shadow (
		.core_clk      (core_clk),
		.rst           (rst),
		.ce            (ce),
		.save          (seq_req.vector_int || seq_req.fast_call),
		.restore       (seq_req.fast_return),
		.live          (core_regs),
		.restore_valid (restore_valid),
		.restored      (restored_regs)
	);

	////////////////////////////////////////////////////////////////////////
	// Interrupt status and mask
	////////////////////////////////////////////////////////////////////////
	always_comb begin
		irq_events          = '0;
		irq_events[EV_FULL] = ev_full;
		irq_events[EV_UNF]  = ev_unf;
	end

	// Sticky bits, write one to clear, a new event wins over the clear
	always_ff @(posedge core_clk) begin
		if (rst) begin
			irq_status_reg <= IRQ_RST;
		end else if (ce) begin
			if (bus_req.wr && reg_hit(bus_req.addr, OFF_IRQ_STATUS)) begin
				irq_status_reg <= (irq_status_reg & ~bus_req.wdata[N_EVENTS-1:0])
				                  | irq_events;
			end else begin
				irq_status_reg <= irq_status_reg | irq_events;
			end
		end
	end

	// Mask, plain read/write
	always_ff @(posedge core_clk) begin
		if (rst) begin
			irq_mask_reg <= IRQ_RST;
		end else if (ce && bus_req.wr && reg_hit(bus_req.addr, OFF_IRQ_MASK)) begin
			irq_mask_reg <= bus_req.wdata[N_EVENTS-1:0];
		end
	end

	// Level output, high while any enabled bit is pending
	always_comb begin
		irq = |(irq_status_reg & irq_mask_reg);
	end

	////////////////////////////////////////////////////////////////////////
	// Read path
	////////////////////////////////////////////////////////////////////////
	// Unmapped offsets read zero; bit 5 of the pointer register too
	always_comb begin
		rd_mux = '0;
		if (reg_hit(bus_req.addr, OFF_TOP_ENTRY_LOW_BYTE)) begin
			rd_mux = tos_q[DATA_W-1:0];
		end else if (reg_hit(bus_req.addr, OFF_TOP_ENTRY_HIGH_BYTE)) begin
			rd_mux = tos_q[2*DATA_W-1:DATA_W];
		end else if (reg_hit(bus_req.addr, OFF_TOP_ENTRY_UPPER_BYTE)) begin
			rd_mux[PC_W-2*DATA_W-1:0] = tos_q[PC_W-1:2*DATA_W];
		end else if (reg_hit(bus_req.addr, OFF_RETURN_STACK_POINTER)) begin
			rd_mux[PTR_W-1:0] = ptr_reg;
			rd_mux[FULL_BIT]  = full_reg;
			rd_mux[UNF_BIT]   = unf_reg;
		end else if (reg_hit(bus_req.addr, OFF_IRQ_STATUS)) begin
			rd_mux[N_EVENTS-1:0] = irq_status_reg;
		end else if (reg_hit(bus_req.addr, OFF_IRQ_MASK)) begin
			rd_mux[N_EVENTS-1:0] = irq_mask_reg;
		end
	end

	// Read data stand only in the cycle after the strobe
	always_ff @(posedge core_clk) begin
		if (rst) begin
			bus_rdata <= '0;
		end else if (ce) begin
			bus_rdata <= bus_req.rd ? rd_mux : '0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Status outputs
	////////////////////////////////////////////////////////////////////////
	// The top entry is registered by the store; the pointer is a flop
	always_comb begin
		top_of_stack = tos_q;
		stack_ptr    = ptr_reg;
	end

endmodule

// >>> rss_top_chk.sv
`timescale 1ns/1ps
module rss_top_chk
	import rss_pkg::*;
(
	input	wire logic			core_clk,
	input	wire logic			rst,
	input	wire logic			ce,
	input	rss_pkg::rss_bus_req_t		bus_req,
	input	wire logic [DATA_W-1:0]		bus_rdata,
	input	rss_pkg::rss_seq_req_t		seq_req,
	input	rss_pkg::rss_core_regs_t	core_regs,
	input	wire logic			stack_error_reset_enable,
	input	wire logic [PC_W-1:0]		top_of_stack,
	input	wire logic [PTR_W-1:0]		stack_ptr,
	input	wire logic			restore_valid,
	input	rss_pkg::rss_core_regs_t	restored_regs,
	input	wire logic			stack_reset_req,
	input	wire logic			irq
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	////////////////////////////////////////////////////////////
	// Taken requests; push beats pop in one cycle
	wire	push_go	= ce & seq_req.push;
	wire	pop_go	= ce & seq_req.pop & ~seq_req.push;
	wire	save_go	= ce & (seq_req.vector_int | seq_req.fast_call);
	wire	err_ev	= (push_go && stack_ptr >= 5'h1e) || (pop_go && stack_ptr == 5'h00);
	sequence s_save;
		save_go && !seq_req.fast_return;
	endsequence
	sequence s_ret;
		ce && seq_req.fast_return && !save_go;
	endsequence
	////////////////////////////////////////////////////////////
	a_push_inc: assert property (push_go && stack_ptr != 5'h1f |=> stack_ptr == 5'($past(stack_ptr) + 5'h01)) else $error("push did not advance pointer");
	a_push_data: assert property (push_go && stack_ptr != 5'h1f |=> top_of_stack == $past(seq_req.pc)) else $error("push did not store pc");
	a_push_sat: assert property (push_go && stack_ptr == 5'h1f |=> $stable(stack_ptr)) else $error("pointer passed maximum");
	a_pop_dec: assert property (pop_go && stack_ptr != 5'h00 |=> stack_ptr == 5'($past(stack_ptr) - 5'h01)) else $error("pop did not step pointer back");
	a_pop_floor: assert property (pop_go && stack_ptr == 5'h00 |=> stack_ptr == 5'h00) else $error("pointer went below zero");
	a_err_on: assert property (err_ev && stack_error_reset_enable |-> ##2 stack_reset_req) else $error("missing reset request");
	a_err_off: assert property (err_ev && !stack_error_reset_enable |-> ##2 !stack_reset_req) else $error("unexpected reset request");
	a_rd_idle: assert property (ce && !bus_req.rd |=> bus_rdata == 8'h00) else $error("read data outside read slot");
	a_rd_ptr: assert property (ce && bus_req.rd && bus_req.addr == OFF_RETURN_STACK_POINTER
		|=> bus_rdata[5:0] == {1'b0, $past(stack_ptr)}) else $error("pointer read wrong");
	a_restore_pulse: assert property (ce |=> restore_valid == $past(seq_req.fast_return)) else $error("restore pulse wrong");
	property p_shadow_trip;
		rss_core_regs_t v;
		(s_save, v = core_regs) ##1 s_ret |=> restored_regs == v;
	endproperty
	a_shadow_trip: assert property (p_shadow_trip) else $error("shadow copy not restored");
endmodule

bind rss_top rss_top_chk rss_top_chk_i (
	.core_clk(core_clk),
	.rst(rst),
	.ce(ce),
	.bus_req(bus_req),
	.bus_rdata(bus_rdata),
	.seq_req(seq_req),
	.core_regs(core_regs),
	.stack_error_reset_enable(stack_error_reset_enable),
	.top_of_stack(top_of_stack),
	.stack_ptr(stack_ptr),
	.restore_valid(restore_valid),
	.restored_regs(restored_regs),
	.stack_reset_req(stack_reset_req),
	.irq(irq)
);

// >>> rss_seq_model.sv
`timescale 1ns/1ps
module rss_seq_model
	import rss_pkg::*;
(
	input	wire logic			core_clk,
	output	rss_pkg::rss_seq_req_t		seq_req,
	output	rss_pkg::rss_core_regs_t	core_regs
);
	import rss_pkg::*;
	////////////////////////////////////////////////////////////
	// Idle at time zero
	initial begin
		seq_req = '0;
		core_regs = '0;
	end
	// Op mask bits: push, pop, vector, call, fast return
	// Second mask follows with no gap when nonzero
	task automatic op(input logic [4:0] m1, input logic [4:0] m2, input logic [PC_W-1:0] p);
		@(posedge core_clk);
		seq_req <= {m1, p};
		@(posedge core_clk);
		if (m2 != 5'h00) begin
			seq_req <= {m2, p};
			@(posedge core_clk);
		end
		// Idle pc is scrambled so a stale value never matches
		seq_req <= {5'h00, ~p};
	endtask
	// Live register set changes only right after an edge
	task automatic set_regs(input rss_core_regs_t v);
		@(posedge core_clk);
		core_regs <= v;
	endtask
endmodule

// >>> test_rss_top.sv
`timescale 1ns/1ps
module test_rss_top;
	import rss_pkg::*;
	logic			core_clk;
	logic			rst;
	logic			ce;
	logic			stack_error_reset_enable;
	rss_bus_req_t		bus_req;
	logic [DATA_W-1:0]	bus_rdata;
	rss_seq_req_t		seq_req;
	rss_core_regs_t		core_regs;
	rss_core_regs_t		restored_regs;
	logic [PC_W-1:0]	top_of_stack;
	logic [PTR_W-1:0]	stack_ptr;
	logic			restore_valid;
	logic			stack_reset_req;
	logic			irq;
	int			n_fail = 0;
	int			tests_run = 0;
	localparam logic [4:0] PUSH = 5'h10, POP = 5'h08, VEC = 5'h04, CALL = 5'h02, RET = 5'h01;
	initial core_clk = 1'b0;
	always #4 core_clk = ~core_clk;
	rss_top rss_top_i (.core_clk(core_clk), .rst(rst), .ce(ce), .bus_req(bus_req),
		.bus_rdata(bus_rdata), .seq_req(seq_req), .core_regs(core_regs),
		.stack_error_reset_enable(stack_error_reset_enable), .top_of_stack(top_of_stack),
		.stack_ptr(stack_ptr), .restore_valid(restore_valid), .restored_regs(restored_regs),
		.stack_reset_req(stack_reset_req), .irq(irq));
	rss_seq_model rss_seq_model_i (.core_clk(core_clk), .seq_req(seq_req), .core_regs(core_regs));
	////////////////////////////////////////////////////////////
	task automatic chk(input string nm, input logic [23:0] seen, input logic [23:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_fail++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
		@(posedge core_clk);
		bus_req <= {1'b1, 1'b0, a, d};
		@(posedge core_clk);
		bus_req <= '0;
	endtask
	// Read data stands only in the cycle after the taking edge
	task automatic rd(input logic [ADDR_W-1:0] a, output logic [7:0] v);
		@(posedge core_clk);
		bus_req <= {1'b0, 1'b1, a, 8'h00};
		@(posedge core_clk);
		bus_req <= '0;
		#1 v = bus_rdata;
	endtask
	function automatic logic [PC_W-1:0] pcv(input int i);
		return PC_W'(i * 21'h0a5a5 + 21'h100000);
	endfunction
	task automatic settle();
		@(posedge core_clk);
		#1;
	endtask
	////////////////////////////////////////////////////////////
	task automatic t_reset();
		logic [7:0] v;
		rd(OFF_RETURN_STACK_POINTER, v);
		chk("pointer reg", v, 8'h00);
		wr(4'hc, 8'hff);
		rd(4'hc, v);
		chk("unmapped", v, 8'h00);
		chk("irq", irq, 1'b0);
	endtask
	task automatic t_push_pop();
		logic [7:0] v;
		for (int i = 1; i <= 3; i++) begin
			rss_seq_model_i.op(PUSH, 5'h00, pcv(i));
			#1 chk("pointer", stack_ptr, i);
			chk("top", top_of_stack, pcv(i));
		end
		rd(OFF_TOP_ENTRY_LOW_BYTE, v);
		chk("low byte", v, pcv(3) & 8'hff);
		rd(OFF_TOP_ENTRY_HIGH_BYTE, v);
		chk("high byte", v, (pcv(3) >> 8) & 8'hff);
		rd(OFF_TOP_ENTRY_UPPER_BYTE, v);
		chk("upper byte", v, pcv(3) >> 16);
		rss_seq_model_i.op(POP, 5'h00, 21'h0);
		#1 chk("pointer", stack_ptr, 2);
		chk("top", top_of_stack, pcv(2));
		wr(OFF_TOP_ENTRY_UPPER_BYTE, 8'hff);
		rd(OFF_TOP_ENTRY_UPPER_BYTE, v);
		chk("upper byte", v, 8'h1f);
		wr(OFF_TOP_ENTRY_LOW_BYTE, 8'h3c);
		settle();
		chk("top", top_of_stack, (pcv(2) & 21'h00ff00) | 21'h1f003c);
	endtask
	task automatic t_full();
		logic [7:0] v;
		@(posedge core_clk);
		stack_error_reset_enable <= 1'b1;
		wr(OFF_RETURN_STACK_POINTER, 8'h1d);
		rss_seq_model_i.op(PUSH, PUSH, pcv(7));
		settle();
		chk("reset req", stack_reset_req, 1'b1);
		settle();
		chk("reset req", stack_reset_req, 1'b0);
		rd(OFF_RETURN_STACK_POINTER, v);
		chk("pointer reg", v, 8'h9f);
		rss_seq_model_i.op(PUSH, 5'h00, pcv(8));
		#1 chk("pointer", stack_ptr, 5'h1f);
		wr(OFF_RETURN_STACK_POINTER, 8'hdf);
		rd(OFF_RETURN_STACK_POINTER, v);
		chk("pointer reg", v, 8'h9f);
		wr(OFF_RETURN_STACK_POINTER, 8'h05);
		rd(OFF_RETURN_STACK_POINTER, v);
		chk("pointer reg", v, 8'h05);
		rd(OFF_IRQ_STATUS, v);
		chk("irq status", v, 8'h01);
		chk("irq", irq, 1'b0);
		wr(OFF_IRQ_MASK, 8'h01);
		#1 chk("irq", irq, 1'b1);
		wr(OFF_IRQ_STATUS, 8'h01);
		#1 chk("irq", irq, 1'b0);
	endtask
	task automatic t_underflow();
		logic [7:0] v;
		@(posedge core_clk);
		stack_error_reset_enable <= 1'b0;
		wr(OFF_RETURN_STACK_POINTER, 8'h00);
		rss_seq_model_i.op(POP, 5'h00, 21'h0);
		#1 chk("pointer", stack_ptr, 5'h00);
		for (int i = 0; i < 3; i++) begin
			settle();
			chk("reset req", stack_reset_req, 1'b0);
		end
		rd(OFF_RETURN_STACK_POINTER, v);
		chk("pointer reg", v, 8'h40);
		@(posedge core_clk);
		stack_error_reset_enable <= 1'b1;
		rss_seq_model_i.op(POP, 5'h00, 21'h0);
		settle();
		chk("reset req", stack_reset_req, 1'b1);
		wr(OFF_RETURN_STACK_POINTER, 8'h00);
		rd(OFF_RETURN_STACK_POINTER, v);
		chk("pointer reg", v, 8'h00);
		// Clock enable low: a push pulse must leave the pointer frozen
		@(posedge core_clk);
		ce <= 1'b0;
		rss_seq_model_i.op(PUSH, 5'h00, pcv(9));
		#1 chk("pointer frozen", stack_ptr, 5'h00);
		@(posedge core_clk);
		ce <= 1'b1;
	endtask
	task automatic t_shadow();
		rss_seq_model_i.set_regs(24'h12a5c3);
		rss_seq_model_i.op(VEC, 5'h00, 21'h0);
		rss_seq_model_i.set_regs(24'h000000);
		rss_seq_model_i.op(RET, 5'h00, 21'h0);
		#1 chk("restore valid", restore_valid, 1'b1);
		chk("restored", restored_regs, 24'h12a5c3);
		settle();
		chk("restore valid", restore_valid, 1'b0);
		rss_seq_model_i.set_regs(24'h3c5a96);
		rss_seq_model_i.op(CALL, RET, 21'h0);
		#1 chk("restored", restored_regs, 24'h3c5a96);
		rss_seq_model_i.set_regs(24'h111111);
		rss_seq_model_i.op(CALL, 5'h00, 21'h0);
		rss_seq_model_i.set_regs(24'heeddcc);
		rss_seq_model_i.op(VEC, RET, 21'h0);
		#1 chk("restored", restored_regs, 24'heeddcc);
	endtask
	////////////////////////////////////////////////////////////
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// Whole run needs about a hundred cycles
	initial begin
		repeat (5000) @(posedge core_clk);
		n_fail++;
		give_verdict();
	end
	initial begin
		rst = 1'b1;
		ce = 1'b1;
		stack_error_reset_enable = 1'b0;
		bus_req = '0;
		repeat (8) @(posedge core_clk);
		rst <= 1'b0;
		t_reset();
		t_push_pop();
		t_full();
		t_underflow();
		t_shadow();
		give_verdict();
	end
endmodule
